// ==== rtl/cpcs_pkg.sv ====
// Constants and types for the card punch cycle sequencer.
// Assumes a 10 MHz system clock; times are held in ms or ns, and all but PERMIT_PERIOD_MS and FIRST_PERMIT_MS are converted to cycles here.
//
// Notes on behaviour
// - Start cycle only with motor running and permissive.
// - Start cycle by issuing a feed command.
// - Issue advance by the full-rate deadline.
// - Raise interrupt when last word stored, if asked.
// - Tolerate first-card delay up to 40 ms.
// - Release transfer area on error-free completion.
package cpcs_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int NS_PER_MS = 1000000;
   localparam int MOTOR_IDLE_MS = 14000;
   localparam int MOTOR_START_MS = 300;
   localparam int PERMIT_PERIOD_MS = 40;
   localparam int CYCLE_MS = 248;
   localparam int FIRST_PERMIT_MS = 200;
   localparam int FIRST_CARD_DELAY_MS = 40;
   localparam int ADVANCE_DEADLINE_MS = 152;
   localparam int CARD_PERIOD_MS = 200;
   localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int MOTOR_IDLE_CYC = MOTOR_IDLE_MS * CYC_PER_MS;
   localparam int MOTOR_START_CYC = MOTOR_START_MS * CYC_PER_MS;
   localparam int CYCLE_CYC = CYCLE_MS * CYC_PER_MS;
   localparam int FIRST_CARD_DELAY_CYC = FIRST_CARD_DELAY_MS * CYC_PER_MS;
   localparam int ADVANCE_DEADLINE_CYC = ADVANCE_DEADLINE_MS * CYC_PER_MS;
   localparam int CARD_PERIOD_CYC = CARD_PERIOD_MS * CYC_PER_MS;
   localparam int CNT_W = 28;

   typedef enum logic [3:0] {
      CPCS_IDLE = 4'h1,
      CPCS_WAIT = 4'h2,
      CPCS_FEED = 4'h4,
      CPCS_RUN  = 4'h8
   } cpcs_state_e;
endpackage : cpcs_pkg

// ==== rtl/cpcs_timer_if.sv ====
// Interface carrying the feed-age timer between sequencer and timer.
// Assumes both ends share clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
interface cpcs_timer_if;
   logic feed_pulse;
   logic motor_idle;
   logic [cpcs_pkg::CNT_W-1:0] age;
   modport owner (input feed_pulse, output motor_idle, output age);
   modport user (output feed_pulse, input motor_idle, input age);
endinterface : cpcs_timer_if
`default_nettype wire

// ==== rtl/cpcs_feed_timer.sv ====
// Counts cycles since the last feed command and flags when the punch motor has timed out.
// Assumes a synchronous feed pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cpcs_feed_timer #(
   parameter int IDLE_CYC = cpcs_pkg::MOTOR_IDLE_CYC
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   cpcs_timer_if.owner tif
);
   import cpcs_pkg::*;
   logic [CNT_W-1:0] age_r;
   logic [CNT_W-1:0] age_nxt;
   logic idle_r;
   logic idle_nxt;

   initial begin
      if (IDLE_CYC < 2 || IDLE_CYC >= (1 << CNT_W)) begin
         $error("IDLE_CYC out of range");
      end
   end

   always_comb begin
      age_nxt = age_r;
      idle_nxt = idle_r;
      if (tif.feed_pulse) begin
         age_nxt = '0;
         idle_nxt = 1'b0;
      end else if (age_r != CNT_W'(IDLE_CYC)) begin
         age_nxt = age_r + CNT_W'(1);
      end else begin
         idle_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         age_r <= '0;
         idle_r <= 1'b1;
      end else begin
         age_r <= age_nxt;
         idle_r <= idle_nxt;
      end
   end

   assign tif.age = age_r;
   assign tif.motor_idle = idle_r;

   AST_IDLE_AFTER_AGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (age_r == CNT_W'(IDLE_CYC) && !tif.feed_pulse) |=> idle_r)
      else $error("motor idle flag not set after interval");
   AST_FEED_CLEARS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      tif.feed_pulse |=> (age_r == '0 && !idle_r))
      else $error("feed did not restart age");
endmodule : cpcs_feed_timer
`default_nettype wire

// ==== rtl/cpcs_sequencer.sv ====
// Top of the card punch cycle sequencer: turns finished output transfers into feed commands.
// Assumes synchronous inputs from transfer logic and the punch mechanism.
`timescale 1ns/1ps
`default_nettype none
module cpcs_sequencer #(
   parameter int IDLE_CYC = cpcs_pkg::MOTOR_IDLE_CYC,
   parameter int START_CYC = cpcs_pkg::MOTOR_START_CYC,
   parameter int CYC_CYC = cpcs_pkg::CYCLE_CYC,
   parameter int DEADLINE_CYC = cpcs_pkg::ADVANCE_DEADLINE_CYC
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic xfer_done_in,
   input wire logic xfer_irq_req_in,
   input wire logic permissive_in,
   input wire logic cycle_done_in,
   input wire logic cycle_error_in,
   output logic feed_cmd_out,
   output logic external_interrupt_signal_out,
   output logic area_release_out,
   output logic cycle_active_out,
   output logic motor_starting_out,
   output logic deadline_miss_out
);
   import cpcs_pkg::*;

   initial begin
      if (START_CYC < 1 || CYC_CYC < 1 || DEADLINE_CYC < 1 || START_CYC >= (1 << CNT_W)) begin
         $error("timing parameter out of range");
      end
   end

   cpcs_timer_if tif ();

   cpcs_feed_timer #(.IDLE_CYC(IDLE_CYC)) u_timer (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .tif(tif)
   );

   // ****************************************
   // Sequencing state
   // ****************************************
   cpcs_state_e state_r;
   cpcs_state_e state_nxt;
   logic [CNT_W-1:0] wait_r;
   logic [CNT_W-1:0] wait_nxt;
   logic [CNT_W-1:0] run_r;
   logic [CNT_W-1:0] run_nxt;
   logic feed_r;
   logic feed_nxt;
   logic irq_r;
   logic irq_nxt;
   logic rel_r;
   logic rel_nxt;
   logic start_r;
   logic start_nxt;
   logic miss_r;
   logic miss_nxt;
   logic pending_r;
   logic pending_nxt;

   assign tif.feed_pulse = feed_r;

   always_comb begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      run_nxt = run_r;
      feed_nxt = 1'b0;
      irq_nxt = 1'b0;
      rel_nxt = 1'b0;
      start_nxt = start_r;
      miss_nxt = 1'b0;
      pending_nxt = pending_r;
      if (xfer_done_in && xfer_irq_req_in) begin
         irq_nxt = 1'b1;
      end
      if (xfer_done_in) begin
         pending_nxt = 1'b1;
      end
      if (cycle_done_in && !cycle_error_in) begin
         rel_nxt = 1'b1;
      end
      if (state_r == CPCS_RUN) begin
         run_nxt = run_r + CNT_W'(1);
      end
      case (state_r)
         CPCS_IDLE: begin
            if (pending_r) begin
               pending_nxt = xfer_done_in;
               wait_nxt = '0;
               state_nxt = CPCS_WAIT;
               start_nxt = tif.motor_idle;
            end
         end
         CPCS_WAIT: begin
            wait_nxt = wait_r + CNT_W'(1);
            if (start_r && wait_r >= CNT_W'(START_CYC - 1)) begin
               start_nxt = 1'b0;
            end
            if (!start_r && permissive_in) begin
               state_nxt = CPCS_FEED;
            end
         end
         CPCS_FEED: begin
            feed_nxt = 1'b1;
            run_nxt = '0;
            state_nxt = CPCS_RUN;
         end
         CPCS_RUN: begin
            if (pending_r && run_r == CNT_W'(DEADLINE_CYC)) begin
               miss_nxt = 1'b1;
            end
            // Next card may wait on permissive.
            if (cycle_done_in || run_r >= CNT_W'(CYC_CYC - 1)) begin
               state_nxt = CPCS_IDLE;
            end else if (pending_r && permissive_in) begin
               pending_nxt = xfer_done_in;
               wait_nxt = '0;
               start_nxt = 1'b0;
               state_nxt = CPCS_FEED;
            end
         end
         default: begin
            state_nxt = CPCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= CPCS_IDLE;
         wait_r <= '0;
         run_r <= '0;
         feed_r <= 1'b0;
         irq_r <= 1'b0;
         rel_r <= 1'b0;
         start_r <= 1'b0;
         miss_r <= 1'b0;
         pending_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
         run_r <= run_nxt;
         feed_r <= feed_nxt;
         irq_r <= irq_nxt;
         rel_r <= rel_nxt;
         start_r <= start_nxt;
         miss_r <= miss_nxt;
         pending_r <= pending_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic active_r;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         active_r <= 1'b0;
      end else begin
         active_r <= (state_nxt == CPCS_RUN);
      end
   end

   assign feed_cmd_out = feed_r;
   assign external_interrupt_signal_out = irq_r;
   assign area_release_out = rel_r;
   assign cycle_active_out = active_r;
   assign motor_starting_out = start_r;
   assign deadline_miss_out = miss_r;

   // ****************************************
   // Checks
   // ****************************************
   AST_FEED_NEEDS_PERMIT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(feed_r) |-> $past(permissive_in, 2) && !$past(start_r, 2))
      else $error("feed issued without permissive point");
   AST_FEED_ONE_CYCLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      feed_r |=> !feed_r ##0 cycle_active_out)
      else $error("feed command not a single pulse");
   AST_IRQ_ON_STORE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (xfer_done_in && xfer_irq_req_in) |=> external_interrupt_signal_out)
      else $error("interrupt not raised after last word");
   AST_NO_IRQ_UNASKED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      external_interrupt_signal_out |-> $past(xfer_done_in) && $past(xfer_irq_req_in))
      else $error("spurious interrupt");
   AST_RELEASE_OK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      area_release_out == $past(cycle_done_in && !cycle_error_in))
      else $error("area release mismatch");
   AST_RESTART_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(motor_starting_out) |-> !feed_r [*2])
      else $error("feed during motor restart");
   AST_HOLD_LENGTH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $fell(motor_starting_out) |-> $past(wait_r) >= CNT_W'(START_CYC - 1))
      else $error("motor restart hold too short");
   AST_NO_FEED_IN_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      motor_starting_out |-> ##2 !feed_r)
      else $error("feed issued while motor restarts");
   AST_IDLE_AT_AGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(tif.motor_idle) |-> tif.age == CNT_W'(IDLE_CYC))
      else $error("motor idle flag before interval");
   AST_MISS_ONLY_PENDING: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      deadline_miss_out |-> $past(pending_r) && $past(state_r == CPCS_RUN))
      else $error("deadline miss without pending card");
   AST_WAIT_TO_FEED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state_r == CPCS_WAIT && !start_r && permissive_in) |-> ##2 feed_r)
      else $error("feed not issued at permissive point");

   COV_FEED: cover property (@(posedge clk_sys_in) disable iff (rst_in) feed_r);
   COV_RESTART: cover property (@(posedge clk_sys_in) disable iff (rst_in) $fell(motor_starting_out));
   COV_IRQ: cover property (@(posedge clk_sys_in) disable iff (rst_in) external_interrupt_signal_out);
   COV_OVERLAP: cover property (@(posedge clk_sys_in) disable iff (rst_in) cycle_active_out ##1 feed_r);
endmodule : cpcs_sequencer
`default_nettype wire

// ==== verif/cpcs_punch_model.sv ====
// Behavioural model of the card punch mechanism facing the sequencer.
// Assumes the sequencer's clock and reset; times are in scaled clock cycles.
`timescale 1ns/1ps
`default_nettype none
module cpcs_punch_model #(
   parameter int LEAVE = 11,
   parameter int ROW1 = 30,
   parameter int ROWS = 59,
   parameter int LEAD = 19,
   parameter int PERM = 8,
   parameter int IDLE = 200,
   parameter int START = 20
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic feed_in,
   input wire logic err_in,
   output logic permissive_out,
   output logic done_out,
   output logic error_out
);
   localparam int CYC = LEAVE + ROW1 + ROWS;
   localparam int FIRST = CYC - LEAD;
   int cnt, idle, hold, free;
   logic run, motor;
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         {permissive_out, done_out, error_out, run, motor} <= '0;
         {cnt, idle, hold, free} <= '0;
      end else begin
         permissive_out <= 1'b0;
         done_out <= 1'b0;
         idle <= feed_in ? 0 : idle + 1;
         if (idle >= IDLE) motor <= 1'b0;
         if (feed_in) begin
            done_out <= run;
            error_out <= err_in;
            run <= 1'b1;
            cnt <= 0;
            hold <= motor ? 0 : START;
            motor <= 1'b1;
         end else if (hold > 0) begin
            hold <= hold - 1;
         end else if (run) begin
            cnt <= cnt + 1;
            if (cnt == CYC - 1) begin
               done_out <= 1'b1;
               error_out <= err_in;
               run <= 1'b0;
            end
            if (cnt >= FIRST && (cnt - FIRST) % PERM == 0) permissive_out <= 1'b1;
         end else begin
            free <= (free == PERM - 1) ? 0 : free + 1;
            if (free == 0) permissive_out <= 1'b1;
         end
      end
   end
endmodule : cpcs_punch_model
`default_nettype wire

// ==== verif/card_punch_cycle_sequencer_tb.sv ====
// Self-checking bench for the card punch cycle sequencer.
// Assumes the punch model answers feeds; counts are scaled down.
`timescale 1ns/1ps
`default_nettype none
module card_punch_cycle_sequencer_tb;
   typedef struct {logic irq; logic err; logic exp_irq; logic exp_rel;} cpcs_row_s;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic xfer_done = 1'b0;
   logic irq_req = 1'b0;
   logic err = 1'b0;
   logic permit, done, cerr, feed, ext, rel, act, mstart, miss;
   int fails = 0, compares = 0;
   int feed_n = 0, irq_n = 0, rel_n = 0, miss_n = 0, start_n = 0, done_n = 0;
   int f0, i0, r0, d0, m0, s0, k;
   cpcs_row_s rows[4] = '{'{1'b0, 1'b0, 1'b0, 1'b1}, '{1'b1, 1'b0, 1'b1, 1'b1},
      '{1'b0, 1'b1, 1'b0, 1'b0}, '{1'b1, 1'b1, 1'b1, 1'b0}};
   always #50 clk_sys_in = ~clk_sys_in;
   cpcs_sequencer #(.IDLE_CYC(200), .START_CYC(20), .CYC_CYC(100), .DEADLINE_CYC(50)) cpcs_sequencer_inst (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .xfer_done_in(xfer_done), .xfer_irq_req_in(irq_req),
      .permissive_in(permit), .cycle_done_in(done), .cycle_error_in(cerr), .feed_cmd_out(feed),
      .external_interrupt_signal_out(ext), .area_release_out(rel), .cycle_active_out(act),
      .motor_starting_out(mstart), .deadline_miss_out(miss));
   cpcs_punch_model cpcs_punch_model_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .feed_in(feed),
      .err_in(err), .permissive_out(permit), .done_out(done), .error_out(cerr));
   always @(posedge clk_sys_in) begin
      feed_n += feed;
      irq_n += ext;
      rel_n += rel;
      miss_n += miss;
      start_n += mstart;
      done_n += done;
   end
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task snap;
      {f0, i0, r0, d0, m0, s0} = {feed_n, irq_n, rel_n, done_n, miss_n, start_n};
   endtask : snap
   task card(input logic irq);
      @(negedge clk_sys_in);
      xfer_done = 1'b1;
      irq_req = irq;
      @(negedge clk_sys_in);
      xfer_done = 1'b0;
      irq_req = 1'b0;
   endtask : card
   task wait_feed(input int n);
      for (k = 0; k < 600 && feed_n - f0 < n; k++) @(negedge clk_sys_in);
   endtask : wait_feed
   task final_report;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      fails++;
      final_report();
   end
   initial begin
      repeat (4) @(negedge clk_sys_in);
      check("reset outputs", {feed, ext, rel, act, mstart, miss}, 16'h0000);
      rst_in = 1'b0;
      $display("test reset done");
      foreach (rows[i]) begin
         snap();
         err = rows[i].err;
         card(rows[i].irq);
         wait_feed(1);
         check("feed", feed_n - f0, 16'h0001);
         check("active", act, 1'b1);
         check("irq", irq_n - i0, rows[i].exp_irq);
         for (k = 0; k < 300 && done_n == d0; k++) @(negedge clk_sys_in);
         repeat (3) @(negedge clk_sys_in);
         check("release", rel_n - r0, rows[i].exp_rel);
         $display("test row %0d done", i);
      end
      err = 1'b0;
      repeat (250) @(negedge clk_sys_in);
      snap();
      card(1'b0);
      wait_feed(1);
      check("restart seen", start_n > s0, 1'b1);
      check("hold long", k >= 20, 1'b1);
      $display("test idle restart done");
      repeat (150) @(negedge clk_sys_in);
      snap();
      card(1'b0);
      card(1'b0);
      wait_feed(1);
      wait_feed(2);
      check("two feeds", feed_n - f0, 16'h0002);
      check("overlap", done_n - d0, 16'h0000);
      check("miss", miss_n > m0, 1'b1);
      $display("test back to back done");
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      check("mid reset", {feed, ext, rel, act, mstart, miss}, 16'h0000);
      rst_in = 1'b0;
      snap();
      card(1'b1);
      repeat (2) @(negedge clk_sys_in);
      check("irq after reset", irq_n - i0, 16'h0001);
      $display("test mid reset done");
      final_report();
   end
endmodule : card_punch_cycle_sequencer_tb
`default_nettype wire
